//--- design/usbsp_map.svh
`ifndef USBSP_MAP_SVH
`define USBSP_MAP_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define USBSP_OFS_CTL0 9'h000
`define USBSP_OFS_ID 9'h001
`define USBSP_OFS_IDCOMP 9'h002
`define USBSP_OFS_INT_STAT 9'h004
`define USBSP_OFS_INT_MASK 9'h005
`define USBSP_OFS_STATUS 9'h006
`define USBSP_OFS_CTL1 9'h007
`define USBSP_OFS_RX_SHIFT 9'h008
`define USBSP_OFS_EP_BASE 9'h010
`define USBSP_EP_COUNT 7

// ****************************************
// Control register 0 fields
// ****************************************
`define USBSP_CTL0_SRST 7
`define USBSP_CTL0_PULLUP 6
`define USBSP_CTL0_RESMEN 5
`define USBSP_CTL0_LPRES 4
`define USBSP_CTL0_VREG 2
`define USBSP_CTL0_PHY 0

// ****************************************
// Interrupt status fields
// ****************************************
`define USBSP_INT_BUSRST 0
`define USBSP_INT_SUSP 1
`define USBSP_INT_RESUME 2
`define USBSP_INT_EOP 3
`define USBSP_INT_SYNC 4

// ****************************************
// Endpoint config fields and receiver constants
// ****************************************
`define USBSP_EP_DIR 2
`define USBSP_EP_DBUF 3
`define USBSP_EP_DBUF_LO 5
`define USBSP_EP_DBUF_HI 6
`define USBSP_RST_BYTE 8'h00
`define USBSP_SYNC_PAT 8'h80
`define USBSP_STUFF_RUN 3'h6

// ****************************************
// Timing
// ****************************************
`define USBSP_CLK_HZ 10000000
`define USBSP_IDLE_MS 3
`define USBSP_BUSRST_NS 2500
`define USBSP_IDLE_CYC (`USBSP_IDLE_MS * (`USBSP_CLK_HZ / 1000))
`define USBSP_BUSRST_CYC \
   ((`USBSP_BUSRST_NS * (`USBSP_CLK_HZ / 1000000) + 999) / 1000)

`endif

//--- design/usbsp_pkg.sv
package usbsp_pkg;
   // Line state as seen on the data pair, full-speed polarity
   typedef enum logic [1:0] {
      USBSP_SE0 = 2'b00,
      USBSP_K = 2'b01,
      USBSP_J = 2'b10,
      USBSP_SE1 = 2'b11
   } usbsp_line_t;
   // Endpoint transfer kinds
   typedef enum logic [1:0] {
      USBSP_EP_CTRL = 2'b00,
      USBSP_EP_INTR = 2'b01,
      USBSP_EP_BULK = 2'b10,
      USBSP_EP_ISO = 2'b11
   } usbsp_ep_t;
endpackage

//--- design/usbsp_sync.sv
`timescale 1ns/10ps
// Three-stage input synchroniser; a change is accepted once the
// second and third stages agree.
module usbsp_sync #(
   parameter logic RST_VAL = 1'b0 // Idle level of the pin
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic d,
   output logic q
);
   logic s1_r, s2_r, s3_r, q_r; // Chain and accepted value
   logic s1_nxt, s2_nxt, s3_nxt, q_nxt;

   // Next values; first stage only feeds the second
   always_comb begin
      s1_nxt = d;
      s2_nxt = s1_r;
      s3_nxt = s2_r;
      q_nxt = (s2_r == s3_r) ? s3_r : q_r;
   end

   // Registers
   always_ff @(posedge clk) begin
      if (rst) begin
         // Idle level, so no false edge follows reset
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
         s3_r <= RST_VAL;
         q_r <= RST_VAL;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
         q_r <= q_nxt;
      end
   end

   assign q = q_r;
endmodule

//--- design/usbsp_top.sv
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "usbsp_map.svh"
module usbsp_top #(
   parameter int IDLE_CYC = `USBSP_IDLE_CYC,
   parameter logic [7:0] PERIPH_ID = 8'h5A // Arbitrary value
) (
   input wire logic REF_CLK,
   input wire logic RESET,
   input wire logic [8:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   input wire logic DP_IN,
   input wire logic DM_IN,
   output logic DP_OUT,
   output logic DM_OUT,
   output logic DP_OE,
   output logic DM_OE,
   output logic PULLUP_EN,
   output logic REG_EN,
   output logic PHY_EN,
   input wire logic PARTIAL_STOP,
   output logic IRQ,
   output logic WAKE_IRQ
);
   import usbsp_pkg::*;

   // ****************************************
   // Declarations
   // ****************************************
   localparam int IW = $clog2(IDLE_CYC + 1); // Idle counter width
   localparam logic [5:0] BUSRST_CYC = 6'(`USBSP_BUSRST_CYC);
   localparam int NEP = `USBSP_EP_COUNT;

   logic dp_s, dm_s; // Synchronised line levels
   usbsp_line_t line; // Decoded line state
   logic mod_rst; // Pin reset or software module reset
   logic srst_r, srst_nxt; // One-cycle soft reset pulse
   logic pullup_r, pullup_nxt;
   logic resmen_r, resmen_nxt;
   logic lpres_r, lpres_nxt;
   logic vreg_r, vreg_nxt;
   logic phy_r, phy_nxt;
   logic rwake_r, rwake_nxt; // Drive K for remote wake
   logic [4:0] stat_r, stat_nxt; // Sticky events
   logic [4:0] mask_r, mask_nxt;
   logic susp_r, susp_nxt; // Suspend flag
   logic [IW-1:0] idle_r, idle_nxt;
   logic [5:0] se0_r, se0_nxt; // SE0 run length
   logic busrst_r, busrst_nxt; // Bus reset seen in this SE0
   usbsp_line_t prev_r, prev_nxt; // Line state one cycle ago
   logic [7:0] shift_r, shift_nxt; // Unstuffed received bits
   logic [2:0] ones_r, ones_nxt; // Run of ones for unstuffing
   logic [3:0] ep_r [NEP]; // Endpoint type, direction, buffering
   logic [3:0] ep_nxt [NEP];
   logic [7:0] ram_r [256]; // Shared buffer RAM
   logic [7:0] rdata_r, rdata_nxt;
   logic irq_r, irq_nxt, wake_r, wake_nxt;
   logic oe_r, oe_nxt, pu_out_r, pu_out_nxt;
   logic [4:0] ev; // Events this cycle
   logic [7:0] ctl0_v;

   // ****************************************
   // Line input synchronisers
   // ****************************************
   // Reset to idle J so no false SE0 or end-of-packet follows
   usbsp_sync #(.RST_VAL(1'b1)) u_sync_dp (
      .clk(REF_CLK),
      .rst(RESET),
      .d(DP_IN),
      .q(dp_s)
   );
   usbsp_sync #(.RST_VAL(1'b0)) u_sync_dm (
      .clk(REF_CLK),
      .rst(RESET),
      .d(DM_IN),
      .q(dm_s)
   );

   // Full-speed polarity: J is positive line high
   assign line = usbsp_line_t'({dp_s, dm_s});
   // Soft reset acts like the pin reset but leaves the input synchronisers and the read data
   assign mod_rst = RESET | srst_r;
   assign ctl0_v = {1'b0, pullup_r, resmen_r, lpres_r, 1'b0, vreg_r,
      1'b0, phy_r};

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      srst_nxt = 1'b0;
      pullup_nxt = pullup_r;
      resmen_nxt = resmen_r;
      vreg_nxt = vreg_r;
      phy_nxt = phy_r;
      rwake_nxt = rwake_r;
      mask_nxt = mask_r;
      for (int i = 0; i < NEP; i++) begin
         ep_nxt[i] = ep_r[i];
      end
      ev = '0;
      // Register writes
      if (WR && ADDR == `USBSP_OFS_CTL0) begin
         srst_nxt = WDATA[`USBSP_CTL0_SRST];
         pullup_nxt = WDATA[`USBSP_CTL0_PULLUP];
         resmen_nxt = WDATA[`USBSP_CTL0_RESMEN];
         vreg_nxt = WDATA[`USBSP_CTL0_VREG];
         phy_nxt = WDATA[`USBSP_CTL0_PHY];
      end
      if (WR && ADDR == `USBSP_OFS_INT_MASK) begin
         mask_nxt = WDATA[4:0];
      end
      if (WR && ADDR == `USBSP_OFS_CTL1) begin
         rwake_nxt = WDATA[0];
      end
      for (int i = 0; i < NEP; i++) begin
         if (WR && ADDR == `USBSP_OFS_EP_BASE + 9'(i)) begin
            // Endpoint 0 is always bidirectional control
            ep_nxt[i] = (i == 0) ? 4'h0 : WDATA[3:0];
            // Double buffering exists only on the last two endpoints
            if (i != `USBSP_EP_DBUF_LO && i != `USBSP_EP_DBUF_HI) begin
               ep_nxt[i][`USBSP_EP_DBUF] = 1'b0;
            end
         end
      end
      // Idle timer: any non-J state is bus activity
      if (line == USBSP_J) begin
         idle_nxt = (idle_r == IW'(IDLE_CYC)) ? idle_r : idle_r + 1'b1;
      end else begin
         idle_nxt = '0;
      end
      susp_nxt = (line == USBSP_J) &&
         (susp_r || idle_r == IW'(IDLE_CYC - 1));
      ev[`USBSP_INT_SUSP] = susp_nxt && !susp_r;
      // Bus reset: SE0 held long enough, reported once
      se0_nxt = (line == USBSP_SE0) ?
         ((se0_r == BUSRST_CYC) ? se0_r : se0_r + 1'b1) : 6'h00;
      busrst_nxt = (line == USBSP_SE0) && (busrst_r || se0_nxt ==
         BUSRST_CYC);
      ev[`USBSP_INT_BUSRST] = busrst_nxt && !busrst_r;
      // End of packet: SE0 returning to J
      ev[`USBSP_INT_EOP] = prev_r == USBSP_SE0 && line == USBSP_J;
      // NRZI: no transition is a one; drop the bit after six ones
      prev_nxt = line;
      shift_nxt = shift_r;
      ones_nxt = ones_r;
      if (line == USBSP_J || line == USBSP_K) begin
         if (ones_r == `USBSP_STUFF_RUN) begin
            ones_nxt = 3'h0;
         end else if (line == prev_r) begin
            shift_nxt = {1'b1, shift_r[7:1]};
            ones_nxt = ones_r + 1'b1;
         end else begin
            shift_nxt = {1'b0, shift_r[7:1]};
            ones_nxt = 3'h0;
         end
      end else begin
         ones_nxt = 3'h0;
      end
      ev[`USBSP_INT_SYNC] = shift_nxt == `USBSP_SYNC_PAT &&
         shift_r != `USBSP_SYNC_PAT;
      // Resume flag: set by K in stop while suspended; the flag is
      // a level held until the enable drops, so a stopped link
      // clock loses nothing once the bus clock returns
      lpres_nxt = resmen_nxt && (lpres_r || (resmen_r && susp_r &&
         PARTIAL_STOP && line == USBSP_K));
      ev[`USBSP_INT_RESUME] = lpres_nxt && !lpres_r;
      // Sticky status; a read clears, a same-cycle event wins
      stat_nxt = stat_r;
      if (RD && ADDR == `USBSP_OFS_INT_STAT) begin
         stat_nxt = 5'h00;
      end
      stat_nxt = stat_nxt | ev;
      irq_nxt = |(stat_nxt & mask_nxt);
      wake_nxt = lpres_nxt;
      // Lines float unless the transceiver is on and driving K
      oe_nxt = phy_nxt && rwake_nxt;
      pu_out_nxt = pullup_nxt;
      // Read data for the next cycle
      rdata_nxt = 8'h00;
      if (RD) begin
         if (ADDR[8]) begin
            rdata_nxt = ram_r[ADDR[7:0]];
         end else begin
            case (ADDR)
               `USBSP_OFS_CTL0: rdata_nxt = ctl0_v;
               `USBSP_OFS_ID: rdata_nxt = PERIPH_ID;
               `USBSP_OFS_IDCOMP: rdata_nxt = ~PERIPH_ID;
               `USBSP_OFS_INT_STAT: rdata_nxt = {3'h0, stat_r};
               `USBSP_OFS_INT_MASK: rdata_nxt = {3'h0, mask_r};
               `USBSP_OFS_STATUS: rdata_nxt = {5'h00, line, susp_r};
               `USBSP_OFS_CTL1: rdata_nxt = {7'h00, rwake_r};
               `USBSP_OFS_RX_SHIFT: rdata_nxt = shift_r;
               default: begin
                  for (int i = 0; i < NEP; i++) begin
                     if (ADDR == `USBSP_OFS_EP_BASE + 9'(i)) begin
                        rdata_nxt = {4'h0, ep_r[i]};
                     end
                  end
               end
            endcase
         end
      end
   end

   // ****************************************
   // State registers
   // ****************************************
   always_ff @(posedge REF_CLK) begin
      if (mod_rst) begin
         // Soft reset also drops every enable (transceiver, regulator, pull-up, resume); firmware restarts them
         srst_r <= 1'b0;
         pullup_r <= 1'b0;
         resmen_r <= 1'b0;
         lpres_r <= 1'b0;
         vreg_r <= 1'b0;
         phy_r <= 1'b0;
         rwake_r <= 1'b0;
         stat_r <= 5'h00;
         mask_r <= 5'h00;
         susp_r <= 1'b0;
         idle_r <= '0;
         se0_r <= 6'h00;
         busrst_r <= 1'b0;
         prev_r <= USBSP_J;
         shift_r <= `USBSP_RST_BYTE;
         ones_r <= 3'h0;
         for (int i = 0; i < NEP; i++) begin
            ep_r[i] <= 4'h0;
         end
         irq_r <= 1'b0;
         wake_r <= 1'b0;
         oe_r <= 1'b0;
         pu_out_r <= 1'b0;
      end else begin
         srst_r <= srst_nxt;
         pullup_r <= pullup_nxt;
         resmen_r <= resmen_nxt;
         lpres_r <= lpres_nxt;
         vreg_r <= vreg_nxt;
         phy_r <= phy_nxt;
         rwake_r <= rwake_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         susp_r <= susp_nxt;
         idle_r <= idle_nxt;
         se0_r <= se0_nxt;
         busrst_r <= busrst_nxt;
         prev_r <= prev_nxt;
         shift_r <= shift_nxt;
         ones_r <= ones_nxt;
         ep_r <= ep_nxt;
         irq_r <= irq_nxt;
         wake_r <= wake_nxt;
         oe_r <= oe_nxt;
         pu_out_r <= pu_out_nxt;
      end
   end

   // Read data is a bus answer, zero without a read; of the resets only the pin reset clears it
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // Buffer RAM keeps its contents over resets, like system RAM
   always_ff @(posedge REF_CLK) begin
      if (WR && ADDR[8]) begin
         ram_r[ADDR[7:0]] <= WDATA;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign RDATA = rdata_r;
   assign DP_OUT = 1'b0; // K state while driving
   assign DM_OUT = oe_r;
   assign DP_OE = oe_r;
   assign DM_OE = oe_r;
   assign PULLUP_EN = pu_out_r;
   assign REG_EN = vreg_r;
   assign PHY_EN = phy_r;
   assign IRQ = irq_r;
   assign WAKE_IRQ = wake_r;

   // ****************************************
   // Checks
   // ****************************************
   srst_clear_a: assert property (@(posedge REF_CLK)
      disable iff (RESET) srst_r |=> !phy_r && !vreg_r && !srst_r)
      else $error("soft reset left enables set");
   susp_time_a: assert property (@(posedge REF_CLK)
      disable iff (mod_rst) $rose(susp_r) |-> idle_r == IW'(IDLE_CYC))
      else $error("suspend set at wrong idle count");
   susp_busy_a: assert property (@(posedge REF_CLK)
      disable iff (mod_rst) line != USBSP_J |=> !susp_r)
      else $error("suspend held during activity");
   lpres_set_a: assert property (@(posedge REF_CLK)
      disable iff (mod_rst) resmen_r && susp_r && PARTIAL_STOP &&
      line == USBSP_K && !WR |=> lpres_r && WAKE_IRQ)
      else $error("resume flag or wake missing");
   lpres_clr_a: assert property (@(posedge REF_CLK)
      disable iff (mod_rst) !resmen_r |-> !lpres_r)
      else $error("resume flag without enable");
   line_hiz_a: assert property (@(posedge REF_CLK)
      disable iff (RESET) !phy_r |-> !DP_OE && !DM_OE)
      else $error("lines driven while transceiver off");
   pullup_out_a: assert property (@(posedge REF_CLK)
      disable iff (RESET) PULLUP_EN == pullup_r)
      else $error("pull-up select not followed");
   busrst_irq_a: assert property (@(posedge REF_CLK)
      disable iff (mod_rst) (line == USBSP_SE0)[*8] ##1
      (line == USBSP_SE0)[*8] ##1 (line == USBSP_SE0)[*8] ##1
      (line == USBSP_SE0) |=> busrst_r)
      else $error("bus reset not flagged");
   busrst_stat_a: assert property (@(posedge REF_CLK)
      disable iff (mod_rst) $rose(busrst_r) |-> stat_r[`USBSP_INT_BUSRST])
      else $error("bus reset event not latched");
   dbuf_only_a: assert property (@(posedge REF_CLK)
      disable iff (mod_rst) !ep_r[1][`USBSP_EP_DBUF] && ep_r[0] == 4'h0)
      else $error("endpoint config illegal");
   ram_read_a: assert property (@(posedge REF_CLK)
      disable iff (RESET) WR && ADDR[8] ##1 RD && ADDR == $past(ADDR)
      |=> RDATA == $past(WDATA, 2))
      else $error("buffer RAM read mismatch");
   susp_c: cover property (@(posedge REF_CLK) $rose(susp_r));
   wake_c: cover property (@(posedge REF_CLK) $rose(WAKE_IRQ));
   busrst_c: cover property (@(posedge REF_CLK) $rose(busrst_r));
   sync_c: cover property (@(posedge REF_CLK) ev[`USBSP_INT_SYNC]);
endmodule

//--- tb/usbsp_host.sv
`timescale 1ns/10ps
// ******************************
// Bus host seen at the data pair
// ******************************
// Behavioural: when the host lets go, the line falls to what the
// resistors give (device pull-up on the positive line, host
// pull-downs elsewhere), never to the last driven value.
module usbsp_host (
   input wire logic drive,
   input var usbsp_pkg::usbsp_line_t line,
   input wire logic dp_out,
   input wire logic dm_out,
   input wire logic dp_oe,
   input wire logic dm_oe,
   input wire logic pullup_en,
   output logic dp_in,
   output logic dm_in
);
   import usbsp_pkg::*;

   // Device drive wins over the host; the bench lets both drive during the remote wake check
   always_comb begin
      if (dp_oe) begin
         dp_in = dp_out;
      end else if (drive) begin
         dp_in = line[1];
      end else begin
         // Released: pull-up makes J, else pull-down makes SE0
         dp_in = pullup_en;
      end
      if (dm_oe) begin
         dm_in = dm_out;
      end else if (drive) begin
         dm_in = line[0];
      end else begin
         dm_in = 1'b0;
      end
   end
endmodule

//--- tb/usbsp_top_bench.sv
`timescale 1ns/10ps
`include "usbsp_map.svh"
// ******************************
// Compare helper
// ******************************
`define CHK(got, exp) begin \
   total_checks++; \
   if ((got) !== (exp)) begin \
      fail_count++; \
      $display("Error at %0t: got %h expected %h", $time, got, exp); \
   end \
end
module usbsp_top_bench;
   import usbsp_pkg::*;
   localparam logic [7:0] ID = 8'hA6; // Arbitrary identity value
   localparam int LIMIT = 3000; // Run needs well under 1000 cycles
   logic REF_CLK = 1'b0;
   logic RESET = 1'b1;
   logic [8:0] ADDR = 9'h000;
   logic [7:0] WDATA = 8'h00;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic PARTIAL_STOP = 1'b0;
   logic [7:0] RDATA;
   logic DP_IN, DM_IN, DP_OUT, DM_OUT, DP_OE, DM_OE;
   logic PULLUP_EN, REG_EN, PHY_EN, IRQ, WAKE_IRQ;
   logic host_drv = 1'b1; // Host drives J until told otherwise
   usbsp_line_t host_line = USBSP_J;
   int fail_count = 0;
   int total_checks = 0;
   int cyc = 0;
   logic [7:0] d;

   // Short idle count keeps the suspend tests brief
   usbsp_top #(.IDLE_CYC(50), .PERIPH_ID(ID)) dut (
      .REF_CLK(REF_CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
      .WR(WR), .RD(RD), .RDATA(RDATA), .DP_IN(DP_IN), .DM_IN(DM_IN),
      .DP_OUT(DP_OUT), .DM_OUT(DM_OUT), .DP_OE(DP_OE), .DM_OE(DM_OE),
      .PULLUP_EN(PULLUP_EN), .REG_EN(REG_EN), .PHY_EN(PHY_EN),
      .PARTIAL_STOP(PARTIAL_STOP), .IRQ(IRQ), .WAKE_IRQ(WAKE_IRQ));
   usbsp_host host (
      .drive(host_drv), .line(host_line), .dp_out(DP_OUT),
      .dm_out(DM_OUT), .dp_oe(DP_OE), .dm_oe(DM_OE),
      .pullup_en(PULLUP_EN), .dp_in(DP_IN), .dm_in(DM_IN));

   // 10 MHz clock
   always #50 REF_CLK = ~REF_CLK;

   // Hang guard
   always @(posedge REF_CLK) begin
      cyc++;
      if (cyc == LIMIT) begin
         fail_count++;
         final_report();
      end
   end

   // ******************************
   // Bus tasks
   // ******************************
   task automatic wr(input logic [8:0] a, input logic [7:0] v);
      @(posedge REF_CLK);
      ADDR <= a;
      WDATA <= v;
      WR <= 1'b1;
      @(posedge REF_CLK);
      WR <= 1'b0;
   endtask

   // Data is taken in the single cycle after the strobe edge
   task automatic rd(input logic [8:0] a, output logic [7:0] v);
      @(posedge REF_CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge REF_CLK);
      RD <= 1'b0;
      #1 v = RDATA;
   endtask

   task automatic rdchk(input logic [8:0] a, input logic [7:0] e);
      logic [7:0] v;
      rd(a, v);
      `CHK(v, e)
   endtask

   // Wait, then let the edge's updates settle before sampling
   task automatic waitc(input int n);
      repeat (n) @(posedge REF_CLK);
      #1;
   endtask

   task automatic set_host(input logic drv, input usbsp_line_t ln);
      @(posedge REF_CLK);
      host_drv <= drv;
      host_line <= ln;
   endtask

   task final_report;
      if (fail_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ******************************
   // Main sequence
   // ******************************
   initial begin
      repeat (20) @(posedge REF_CLK);
      RESET <= 1'b0;
      waitc(1);
      // Reset state: enables off, lines undriven
      `CHK({PHY_EN, REG_EN, PULLUP_EN, DP_OE, DM_OE}, 5'h00)
      rdchk(`USBSP_OFS_CTL0, 8'h00);
      rdchk(`USBSP_OFS_ID, ID);
      rdchk(`USBSP_OFS_IDCOMP, ~ID);
      wr(9'h003, 8'hFF); // Unmapped write must vanish
      rdchk(9'h003, 8'h00);
      // Remote wake drive asked for while transceiver is off
      wr(`USBSP_OFS_CTL1, 8'h01);
      waitc(2);
      `CHK({DP_OE, DM_OE}, 2'b00)
      wr(`USBSP_OFS_CTL0, 8'h45);
      waitc(2);
      `CHK({PHY_EN, REG_EN, PULLUP_EN}, 3'b111)
      `CHK({DP_OE, DM_OE, DP_OUT, DM_OUT}, 4'b1101)
      wr(`USBSP_OFS_CTL1, 8'h00);
      rdchk(`USBSP_OFS_CTL0, 8'h45);
      // Endpoint types; double buffer kept only on 5 and 6
      for (int i = 0; i < 7; i++) begin
         wr(9'(16 + i), 8'h0F);
      end
      for (int i = 0; i < 7; i++) begin
         rdchk(9'(16 + i), i == 0 ? 8'h00 : (i > 4 ? 8'h0F : 8'h07));
      end
      // Shared RAM at both ends of its range
      wr(9'h100, 8'h3C);
      wr(9'h1FF, 8'hC3);
      rdchk(9'h100, 8'h3C);
      rdchk(9'h1FF, 8'hC3);
      // Write then read of one RAM byte back to back, no gap
      @(posedge REF_CLK);
      ADDR <= 9'h1A5;
      WDATA <= 8'h5C;
      WR <= 1'b1;
      @(posedge REF_CLK);
      WR <= 1'b0;
      RD <= 1'b1;
      @(posedge REF_CLK);
      RD <= 1'b0;
      #1;
      `CHK(RDATA, 8'h5C)
      // Host bus reset: long SE0 raises the masked interrupt
      rd(`USBSP_OFS_INT_STAT, d);
      wr(`USBSP_OFS_INT_MASK, 8'h01);
      set_host(1'b1, USBSP_SE0);
      waitc(30);
      `CHK(IRQ, 1'b1)
      set_host(1'b1, USBSP_J);
      waitc(5);
      rd(`USBSP_OFS_INT_STAT, d);
      `CHK(d & 8'h09, 8'h09)
      waitc(1);
      `CHK(IRQ, 1'b0)
      // Suspend after the idle count, not before
      wr(`USBSP_OFS_INT_MASK, 8'h06);
      set_host(1'b1, USBSP_K);
      waitc(5);
      set_host(1'b0, USBSP_J); // Released: pull-up holds J
      waitc(40);
      rdchk(`USBSP_OFS_STATUS, 8'h04);
      waitc(25);
      rdchk(`USBSP_OFS_STATUS, 8'h05);
      `CHK(IRQ, 1'b1)
      rd(`USBSP_OFS_INT_STAT, d);
      `CHK(d[1], 1'b1)
      // K without partial stop is refused
      wr(`USBSP_OFS_CTL0, 8'h65);
      set_host(1'b1, USBSP_K);
      waitc(6);
      `CHK(WAKE_IRQ, 1'b0)
      rdchk(`USBSP_OFS_CTL0, 8'h65);
      // Suspend again, enter partial stop, then resume K
      set_host(1'b0, USBSP_J);
      waitc(60);
      rd(`USBSP_OFS_INT_STAT, d);
      @(posedge REF_CLK);
      PARTIAL_STOP <= 1'b1;
      set_host(1'b1, USBSP_K);
      for (int i = 0; i < 8 && WAKE_IRQ !== 1'b1; i++) begin
         waitc(1);
      end
      `CHK(WAKE_IRQ, 1'b1)
      `CHK(IRQ, 1'b1)
      @(posedge REF_CLK);
      PARTIAL_STOP <= 1'b0;
      rdchk(`USBSP_OFS_CTL0, 8'h75);
      // Firmware drops wake enable at once after waking
      wr(`USBSP_OFS_CTL0, 8'h45);
      waitc(2);
      `CHK(WAKE_IRQ, 1'b0)
      rdchk(`USBSP_OFS_CTL0, 8'h45);
      set_host(1'b1, USBSP_J);
      // Regulator and transceiver off before any deeper stop
      wr(`USBSP_OFS_CTL0, 8'h40);
      waitc(2);
      `CHK({PHY_EN, REG_EN}, 2'b00)
      // Soft reset clears the module and itself
      wr(`USBSP_OFS_CTL0, 8'hC5);
      waitc(3);
      `CHK({PHY_EN, REG_EN, PULLUP_EN}, 3'b000)
      rdchk(`USBSP_OFS_CTL0, 8'h00);
      rdchk(9'h011, 8'h00);
      rdchk(`USBSP_OFS_INT_MASK, 8'h00);
      // Steady J decodes as ones, stuffed bits dropped
      waitc(4);
      rdchk(`USBSP_OFS_RX_SHIFT, 8'hFF);
      final_report();
   end
endmodule
